/* File: include/csl_defs.vh */
// Purpose: shared constants of the configuration switch loader
// Assumes: switch 1 is bit 7 of the switch word, switch 8 is bit 0
// Notes: down reads as 0, up reads as 1
`ifndef CSL_DEFS_VH
`define CSL_DEFS_VH

`define CSL_CLK_HZ        10000000
`define CSL_DEBOUNCE_US   10000
`define CSL_DEBOUNCE_CYC  (`CSL_DEBOUNCE_US * (`CSL_CLK_HZ / 1000000))

// set selector, switches 1 and 2
`define CSL_SEL_HI        7
`define CSL_SEL_LO        6
`define CSL_SET_ADDR      2'h0
`define CSL_SET_SERIAL    2'h1
`define CSL_SET_RSVD      2'h2
`define CSL_SET_BOOT      2'h3

// field positions inside the switch word
`define CSL_FLD_HI        5
`define CSL_BAUD_LO       3
`define CSL_DBITS_BIT     2
`define CSL_PAR_HI        1
`define CSL_SYS_BIT       4
// the service field spans switches 4 and 5; either one up keeps the firmware resident
`define CSL_SYS_ALT_BIT   3
`define CSL_FC_BIT        0

// stored set defaults after loss of the backed store
`define CSL_ADDR_RST      6'h16
`define CSL_SER_RST       6'h34

`define CSL_PAR_NONE      2'h0
`define CSL_PAR_ODD       2'h1
`define CSL_PAR_EVEN      2'h2

`define CSL_BAUD_1200     1200
`define CSL_BAUD_2400     2400
`define CSL_BAUD_4800     4800
`define CSL_BAUD_9600     9600
`define CSL_BAUD_14400    14400
`define CSL_BAUD_19200    19200
`define CSL_BAUD_38400    38400

// apb byte offsets
`define CSL_REG_STATUS    12'h000
`define CSL_REG_CTRL      12'h004
`define CSL_REG_ADDR      12'h008
`define CSL_REG_SERIAL    12'h00c
`define CSL_REG_TXDATA    12'h010
`define CSL_REG_RXDATA    12'h014
`define CSL_REG_MODEM     12'h018
`define CSL_REG_SWITCH    12'h01c

`define CSL_STAT_ERR_LO   9
`define CSL_CTRL_RST      2'h0

`endif

/* File: hw/csl_sw_sampler.v */
// Purpose: one-shot debounced capture of the eight configuration switches
// Assumes: sw_in synchronous to core_clk
// Notes: after capture the value is frozen until the next reset
`timescale 1ns/1ps
`include "csl_defs.vh"
module csl_sw_sampler #(
	parameter DEBOUNCE_CYC = `CSL_DEBOUNCE_CYC
) (
	input  wire       core_clk,
	input  wire       sys_rst,
	input  wire [7:0] sw_in,
	output reg  [7:0] sw_val,
	output reg        sw_done
);
	reg [7:0]  last;
	reg [23:0] cnt;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			last    <= 8'h00;
			cnt     <= 24'h000000;
			sw_val  <= 8'h00;
			sw_done <= 1'b0;
		end else if (!sw_done) begin
			if (sw_in != last) begin
				last <= sw_in;
				cnt  <= 24'h000000;
			end else if (cnt == DEBOUNCE_CYC[23:0] - 24'h000001) begin
				sw_val  <= last;
				sw_done <= 1'b1;
			end else begin
				cnt <= cnt + 24'h000001;
			end
		end
	end
endmodule // csl_sw_sampler

/* File: hw/csl_nv_store.v */
// Purpose: battery-backed store of the bus address set and the serial set
// Assumes: nv_rst only on loss of the backing supply, not at power-up
// Notes: each set has its own write strobe
`timescale 1ns/1ps
`include "csl_defs.vh"
module csl_nv_store (
	input  wire       core_clk,
	input  wire       nv_rst,
	input  wire [1:0] set_we,
	input  wire [5:0] wdata,
	output wire [5:0] nv_addr,
	output wire [5:0] nv_ser
);
	reg [5:0] mem [0:1];

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_set
			// a set changes only on nv_rst or its own strobe, so the other set survives
			always @(posedge core_clk) begin
				if (nv_rst)
					mem[i] <= (i == 0) ? `CSL_ADDR_RST : `CSL_SER_RST;
				else if (set_we[i])
					mem[i] <= wdata;
			end
		end
	endgenerate

	assign nv_addr = mem[0];
	assign nv_ser  = mem[1];
endmodule // csl_nv_store

/* File: hw/csl_loader.v */
// Purpose: power-up switch decode, set commit, serial dce port, apb registers
// Assumes: sys_rst is the power-on reset; all inputs synchronous to core_clk
// Notes: apb answers with no wait state; serial lines are logic level, 1 = asserted
// Operation
// - switches 1 and 2 pick address, serial, reserved or service boot set.
// - address set takes the bus address from switches 3 to 8.
// - switch changes commit to backed storage only at the next power-up.
// - a committed set persists until reselected, changed and power cycled.
// - committing one set leaves the other stored set untouched.
// - default bus address is 22, switch pattern 00010110.
// - down switch reads as 0, up switch reads as 1.
// - serial link uses only rts and cts hardware flow control.
// - serial set: switches 3-5 baud, 6 data width, 7-8 parity.
// - drive txd, dtr, rts; receive rxd, dcd, dsr, cts, ri as dce.
// - boot set: switch 4 or 5 stay resident, switch 8 forced cold start.
// - baud, data width and parity codes decode per the documented tables.
// - each character has exactly one start and one stop bit.
// - pattern 11000001 forces a cold start erasing methods, keeping logs.
// - pattern 11001000 keeps firmware resident with basic functions only.
`timescale 1ns/1ps
`include "csl_defs.vh"
module csl_loader #(
	parameter DEBOUNCE_CYC = `CSL_DEBOUNCE_CYC
) (
	input  wire        core_clk,
	input  wire        sys_rst,
	input  wire        nv_rst,
	input  wire [7:0]  sw_in,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output reg         txd_out,
	output wire        dtr_out,
	output wire        rts_out,
	input  wire        rxd_in,
	input  wire        dcd_in,
	input  wire        dsr_in,
	input  wire        cts_in,
	input  wire        ri_in,
	output wire        cfg_ready,
	output wire [5:0]  bus_addr,
	output reg         stay_resident,
	output reg         cold_start_req
);
	localparam ST_SAMPLE = 2'h0;
	localparam ST_COMMIT = 2'h1;
	localparam ST_RUN    = 2'h2;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	wire [7:0]  sw_val;
	wire        sw_done;
	wire [5:0]  nv_ser;
	reg  [1:0]  set_we;
	reg  [1:0]  ctrl;
	reg         par_err;
	reg         frm_err;
	reg         ovr_err;

	csl_sw_sampler #(
		.DEBOUNCE_CYC(DEBOUNCE_CYC)
	) u_sampler (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.sw_in   (sw_in),
		.sw_val  (sw_val),
		.sw_done (sw_done)
	);

	// switch word taken as-is: up = 1, switch 1 at bit 7
	wire [1:0] sel = sw_val[`CSL_SEL_HI:`CSL_SEL_LO];

	csl_nv_store u_store (
		.core_clk(core_clk),
		.nv_rst  (nv_rst),
		.set_we  (set_we),
		.wdata   (sw_val[`CSL_FLD_HI:0]),
		.nv_addr (bus_addr),
		.nv_ser  (nv_ser)
	);

	always @* begin
		next_state = state;
		set_we     = 2'h0;
		case (state)
			ST_SAMPLE: if (sw_done) next_state = ST_COMMIT;
			ST_COMMIT: begin
				// single write per power-up; reserved and boot sets store nothing
				set_we[0]  = (sel == `CSL_SET_ADDR);
				set_we[1]  = (sel == `CSL_SET_SERIAL);
				next_state = ST_RUN;
			end
			ST_RUN: next_state = ST_RUN;
			default: next_state = ST_SAMPLE;
		endcase
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			state          <= ST_SAMPLE;
			stay_resident  <= 1'b0;
			cold_start_req <= 1'b0;
		end else begin
			state          <= next_state;
			cold_start_req <= 1'b0;
			if (state == ST_COMMIT && sel == `CSL_SET_BOOT) begin
				stay_resident  <= sw_val[`CSL_SYS_BIT] | sw_val[`CSL_SYS_ALT_BIT];
				cold_start_req <= sw_val[`CSL_FC_BIT];
			end
		end
	end

	assign cfg_ready = (state == ST_RUN);

	// serial settings from the stored set
	wire [2:0] baud_code = nv_ser[`CSL_FLD_HI:`CSL_BAUD_LO];
	wire       dbits8    = nv_ser[`CSL_DBITS_BIT];
	wire [1:0] par_mode  = nv_ser[`CSL_PAR_HI:0];
	// code 11 is undefined; treated as no parity
	wire       par_en    = (par_mode == `CSL_PAR_ODD) || (par_mode == `CSL_PAR_EVEN);
	wire [3:0] nbits     = 4'h9 + {3'h0, dbits8} + {3'h0, par_en};

	function [13:0] div_of;
		input [2:0] c;
		reg   [31:0] d;
		begin
			case (c)
				3'h1: d = `CSL_CLK_HZ / `CSL_BAUD_1200;
				3'h2: d = `CSL_CLK_HZ / `CSL_BAUD_2400;
				3'h3: d = `CSL_CLK_HZ / `CSL_BAUD_4800;
				3'h5: d = `CSL_CLK_HZ / `CSL_BAUD_14400;
				3'h6: d = `CSL_CLK_HZ / `CSL_BAUD_19200;
				3'h7: d = `CSL_CLK_HZ / `CSL_BAUD_38400;
				default: d = `CSL_CLK_HZ / `CSL_BAUD_9600;
			endcase
			div_of = d[13:0];
		end
	endfunction
	wire [13:0] div = div_of(baud_code);

	// apb decode
	wire acc    = psel && penable;
	wire wr     = acc && pwrite;
	wire hit_st = (paddr == `CSL_REG_STATUS);
	wire hit_tx = (paddr == `CSL_REG_TXDATA);
	wire hit_rx = (paddr == `CSL_REG_RXDATA);
	wire mapped = hit_st || hit_tx || hit_rx || (paddr == `CSL_REG_CTRL) ||
		(paddr == `CSL_REG_ADDR) || (paddr == `CSL_REG_SERIAL) ||
		(paddr == `CSL_REG_MODEM) || (paddr == `CSL_REG_SWITCH);
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// transmitter: holding byte plus shifter
	reg  [7:0]  tx_hold;
	reg         tx_full;
	reg         tx_busy;
	reg  [10:0] tx_sh;
	reg  [3:0]  tx_left;
	reg  [13:0] tx_cnt;
	reg  [10:0] frm;
	wire        run   = cfg_ready;
	wire        pbit  = (dbits8 ? ^tx_hold : ^tx_hold[6:0]) ^ (par_mode == `CSL_PAR_ODD);

	always @* begin
		case ({dbits8, par_en})
			2'h0: frm = {3'h7, tx_hold[6:0], 1'b0};
			2'h1: frm = {2'h3, pbit, tx_hold[6:0], 1'b0};
			2'h2: frm = {2'h3, tx_hold, 1'b0};
			default: frm = {1'b1, pbit, tx_hold, 1'b0};
		endcase
	end

	wire tx_load = wr && hit_tx && !tx_full;
	wire tx_go   = run && tx_full && !tx_busy && cts_in;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			tx_hold <= 8'h00;
			tx_full <= 1'b0;
			tx_busy <= 1'b0;
			tx_sh   <= 11'h7ff;
			tx_left <= 4'h0;
			tx_cnt  <= 14'h0000;
			txd_out <= 1'b1;
		end else begin
			if (tx_load) begin
				tx_hold <= pwdata[7:0];
				tx_full <= 1'b1;
			end
			if (tx_go) begin
				tx_full <= 1'b0;
				tx_busy <= 1'b1;
				tx_sh   <= {1'b1, frm[10:1]};
				txd_out <= frm[0];
				tx_left <= nbits - 4'h1;
				tx_cnt  <= div - 14'h0001;
			end else if (tx_busy) begin
				if (tx_cnt != 14'h0000) begin
					tx_cnt <= tx_cnt - 14'h0001;
				end else if (tx_left == 4'h0) begin
					tx_busy <= 1'b0;
				end else begin
					txd_out <= tx_sh[0];
					tx_sh   <= {1'b1, tx_sh[10:1]};
					tx_left <= tx_left - 4'h1;
					tx_cnt  <= div - 14'h0001;
				end
			end
		end
	end

	// receiver: mid-bit sampling from the start edge
	reg         rx_busy;
	reg         rx_fin;
	reg  [3:0]  rx_idx;
	reg  [13:0] rx_cnt;
	reg  [10:0] rx_sh;
	reg  [7:0]  rx_data;
	reg         rx_full;
	wire        rx_en   = run && ctrl[1];
	wire [10:0] rx_al   = rx_sh >> (4'hb - nbits);
	wire [7:0]  rx_byte = dbits8 ? rx_al[8:1] : {1'b0, rx_al[7:1]};
	wire        rx_par  = dbits8 ? rx_al[9] : rx_al[8];
	wire        rx_bad  = par_en &&
		((^rx_byte ^ rx_par) != (par_mode == `CSL_PAR_ODD));
	wire        rx_stop = rx_al[nbits - 4'h1];
	wire        rx_take = acc && !pwrite && hit_rx;
	wire        rx_put  = rx_fin && rx_stop && !rx_full;
	wire        err_clr = wr && hit_st;

	// rts stays low while the receive byte is unread
	assign rts_out = rx_en && !rx_full;
	assign dtr_out = ctrl[0];

	always @(posedge core_clk) begin
		if (sys_rst) begin
			rx_busy <= 1'b0;
			rx_fin  <= 1'b0;
			rx_idx  <= 4'h0;
			rx_cnt  <= 14'h0000;
			rx_sh   <= 11'h000;
			rx_data <= 8'h00;
			rx_full <= 1'b0;
			par_err <= 1'b0;
			frm_err <= 1'b0;
			ovr_err <= 1'b0;
		end else begin
			rx_fin <= 1'b0;
			if (!rx_busy) begin
				if (rx_en && !rxd_in) begin
					rx_busy <= 1'b1;
					rx_idx  <= 4'h0;
					rx_cnt  <= {1'b0, div[13:1]};
				end
			end else if (rx_cnt != 14'h0000) begin
				rx_cnt <= rx_cnt - 14'h0001;
			end else if (rx_idx == 4'h0 && rxd_in) begin
				rx_busy <= 1'b0;
			end else begin
				rx_sh  <= {rxd_in, rx_sh[10:1]};
				rx_cnt <= div - 14'h0001;
				rx_idx <= rx_idx + 4'h1;
				if (rx_idx == nbits - 4'h1) begin
					// leave at mid stop bit so a next start edge is caught
					rx_busy <= 1'b0;
					rx_fin  <= 1'b1;
				end
			end
			// a new byte arriving at the read wins over the clear
			if (rx_take)
				rx_full <= 1'b0;
			if (rx_fin && rx_stop && (!rx_full || rx_take)) begin
				rx_data <= rx_byte;
				rx_full <= 1'b1;
			end
			// sticky errors, write 1 to clear, set wins
			if (err_clr) begin
				par_err <= par_err && !pwdata[`CSL_STAT_ERR_LO];
				frm_err <= frm_err && !pwdata[`CSL_STAT_ERR_LO + 1];
				ovr_err <= ovr_err && !pwdata[`CSL_STAT_ERR_LO + 2];
			end
			if (rx_fin && rx_stop && rx_bad)
				par_err <= 1'b1;
			if (rx_fin && !rx_stop)
				frm_err <= 1'b1;
			if (rx_put == 1'b0 && rx_fin && rx_stop && rx_full && !rx_take)
				ovr_err <= 1'b1;
		end
	end

	// control register
	always @(posedge core_clk) begin
		if (sys_rst)
			ctrl <= `CSL_CTRL_RST;
		else if (wr && paddr == `CSL_REG_CTRL)
			ctrl <= pwdata[1:0];
	end

	// read data registered in the setup cycle, valid through the access cycle
	wire [31:0] stat = {20'h00000, ovr_err, frm_err, par_err, rx_full, tx_busy,
		tx_full, (sel == `CSL_SET_RSVD), cold_start_req, stay_resident,
		cfg_ready, sel};
	reg  [31:0] rd_mux;

	always @* begin
		case (paddr)
			`CSL_REG_STATUS: rd_mux = stat;
			`CSL_REG_CTRL:   rd_mux = {30'h00000000, ctrl};
			`CSL_REG_ADDR:   rd_mux = {26'h0000000, bus_addr};
			`CSL_REG_SERIAL: rd_mux = {26'h0000000, nv_ser};
			`CSL_REG_RXDATA: rd_mux = {24'h000000, rx_data};
			`CSL_REG_MODEM:  rd_mux = {28'h0000000, ri_in, cts_in, dsr_in, dcd_in};
			`CSL_REG_SWITCH: rd_mux = {24'h000000, sw_val};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge core_clk) begin
		if (sys_rst)
			prdata <= 32'h00000000;
		else if (psel && !penable)
			prdata <= rd_mux;
	end
endmodule // csl_loader

/* File: tb/csl_loader_properties.sv */
// Purpose: port checks of the switch loader
// Assumes: switches steady from reset until loading ends
// Notes: sys_rst disables every check
`timescale 1ns/1ps
module csl_loader_properties (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       nv_rst,
	input wire logic [7:0] sw_in,
	input wire logic       cfg_ready,
	input wire logic [5:0] bus_addr,
	input wire logic       stay_resident,
	input wire logic       cold_start_req,
	input wire logic       rts_out,
	input wire logic       txd_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_READY_HOLD: assert property (cfg_ready |=> cfg_ready)
		else $error("ready fell");
	AST_ADDR_HOLD: assert property (cfg_ready && !nv_rst |=> $stable(bus_addr))
		else $error("address moved");
	AST_ADDR_LOAD: assert property ($rose(cfg_ready) && sw_in[7:6] == 2'h0
		|-> bus_addr == sw_in[5:0]) else $error("address not loaded");
	// the serial set, when selected, is written on the same edge that raises ready, so compare against an earlier value
	AST_ADDR_KEEP: assert property ($rose(cfg_ready) && sw_in[7:6] != 2'h0
		|-> bus_addr == $past(bus_addr, 6)) else $error("address hit");
	AST_BOOT_SYS: assert property ($rose(cfg_ready)
		|-> stay_resident == (sw_in[7:6] == 2'h3 && (sw_in[4] || sw_in[3])))
		else $error("stay bad");
	AST_SYS_STABLE: assert property (cfg_ready |=> $stable(stay_resident))
		else $error("stay moved");
	AST_COLD_CAUSE: assert property ($rose(cold_start_req)
		|-> sw_in[7:6] == 2'h3 && sw_in[0]) else $error("cold bad");
	AST_COLD_PULSE: assert property (cold_start_req |=> !cold_start_req)
		else $error("cold long");
	AST_RTS_GATE: assert property (rts_out |-> cfg_ready)
		else $error("rts early");
	AST_TX_IDLE: assert property (!cfg_ready |-> txd_out)
		else $error("txd busy");
	AST_BIT_LEN: assert property ($fell(txd_out) |-> !txd_out [*8])
		else $error("bit short");
endmodule // csl_loader_properties

bind csl_loader csl_loader_properties u_prop (.core_clk(core_clk), .sys_rst(sys_rst),
	.nv_rst(nv_rst), .sw_in(sw_in), .cfg_ready(cfg_ready), .bus_addr(bus_addr),
	.stay_resident(stay_resident), .cold_start_req(cold_start_req), .rts_out(rts_out),
	.txd_out(txd_out));

/* File: tb/csl_host_model.sv */
// Purpose: switch bank and host terminal on the serial port
// Assumes: 8 data bits, no parity, DIV cycles a bit
// Notes: host sends one byte per tx_req step
`timescale 1ns/1ps
module csl_host_model #(
	parameter DIV = 260
) (
	input  wire logic       core_clk,
	input  wire logic [7:0] sw_set,
	input  wire logic       cts_set,
	output logic [7:0]      sw_in,
	input  wire logic       txd_out,
	input  wire logic       rts_out,
	output logic            rxd_in,
	output logic            cts_in,
	output logic            dcd_in,
	output logic            dsr_in,
	output logic            ri_in,
	input  wire logic [7:0] tx_byte,
	input  int              tx_req,
	output logic [7:0]      got,
	output int              got_n
);
	int sent = 0;
	assign sw_in = sw_set;
	assign cts_in = cts_set;
	assign dcd_in = 1'b1;
	assign dsr_in = 1'b1;
	assign ri_in = 1'b0;
	initial got_n = 0;
	initial rxd_in = 1'b1;
	always begin
		@(negedge txd_out);
		repeat (DIV / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge core_clk);
			got[i] = txd_out;
		end
		repeat (DIV) @(posedge core_clk);
		if (txd_out === 1'b1) got_n++;
	end
	// no software flow control: only rts lets a character out
	always begin
		wait (tx_req != sent && rts_out === 1'b1);
		@(posedge core_clk);
		rxd_in <= 1'b0;
		repeat (DIV) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			rxd_in <= tx_byte[i];
			repeat (DIV) @(posedge core_clk);
		end
		rxd_in <= 1'b1;
		repeat (DIV) @(posedge core_clk);
		sent++;
	end
endmodule // csl_host_model

/* File: tb/config_switch_param_loader_bench.sv */
// Purpose: power-up loading, stored sets and serial port of the loader
// Assumes: debounce shortened to 8 cycles
// Notes: each pwr call is one power cycle
`timescale 1ns/1ps
module config_switch_param_loader_bench;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        nv_rst = 1'b1;
	logic [7:0]  sw_set = 8'hc8;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd, r, a;
	logic [7:0]  hb, got, sw_in;
	logic        er, cs;
	logic        cts_set = 1'b1;
	int          tx_req = 0, got_n, err_total = 0, compares = 0, k;
	wire [31:0]  prdata;
	wire [5:0]   bus_addr;
	wire pready, pslverr, txd_out, dtr_out, rts_out, rxd_in, dcd_in, dsr_in, cts_in, ri_in;
	wire cfg_ready, stay_resident, cold_start_req;
	always #50 core_clk = ~core_clk;
	csl_loader #(.DEBOUNCE_CYC(8)) i_dut (.core_clk, .sys_rst, .nv_rst, .sw_in, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txd_out, .dtr_out,
		.rts_out, .rxd_in, .dcd_in, .dsr_in, .cts_in, .ri_in, .cfg_ready, .bus_addr,
		.stay_resident, .cold_start_req);
	csl_host_model #(.DIV(260)) i_host (.core_clk, .sw_set, .cts_set, .sw_in, .txd_out, .rts_out,
		.rxd_in, .cts_in, .dcd_in, .dsr_in, .ri_in, .tx_byte(hb), .tx_req, .got, .got_n);
	task test_done;
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// nv_rst goes with the first reset only, as a fresh backed store
	task pwr(input logic [7:0] s);
		int n;
		sw_set  <= s;
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		nv_rst  <= 1'b0;
		n = 0;
		// look between edges: the cold start pulse stands one cycle from ready
		while (cfg_ready !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		cs = cold_start_req;
		chk(cfg_ready, 1);
		@(posedge core_clk);
	endtask
	initial begin
		repeat (30000) @(posedge core_clk);
		err_total++;
		test_done;
	end
	initial begin
		k = $urandom(32'hf7d4);
		pwr(8'hc8);
		chk(stay_resident, 1);
		chk(cs, 0);
		apb(0, 12'h008, 0);
		chk(rd, 32'h16);
		pwr(8'hc1);
		chk(stay_resident, 0);
		chk(cs, 1);
		apb(0, 12'h01c, 0);
		chk(rd, 32'hc1);
		repeat (3) begin
			r = $urandom;
			pwr({2'h0, r[5:0]});
			chk(bus_addr, r[5:0]);
			sw_set <= {2'h0, ~r[5:0]};
			repeat (20) @(posedge core_clk);
			apb(0, 12'h008, 0);
			chk(rd, r[5:0]);
			pwr({2'h2, ~r[5:0]});
			apb(0, 12'h008, 0);
			chk(rd, r[5:0]);
			a = $urandom;
			pwr({2'h1, a[5:0]});
			apb(0, 12'h00c, 0);
			chk(rd, a[5:0]);
			apb(0, 12'h008, 0);
			chk(rd, r[5:0]);
		end
		pwr(8'h7c);
		apb(1, 12'h004, 32'h3);
		@(negedge core_clk);
		chk(dtr_out, 1);
		apb(0, 12'h018, 0);
		chk(rd, 32'h7);
		r = $urandom;
		k = got_n;
		// with cts low the byte must wait in the holding register
		cts_set <= 1'b0;
		apb(1, 12'h010, r);
		repeat (50) @(posedge core_clk);
		apb(0, 12'h000, 0);
		chk(rd[7:6], 2'h1);
		cts_set <= 1'b1;
		for (int i = 0; i < 4000 && got_n == k; i++) @(posedge core_clk);
		chk(got_n, k + 1);
		chk(got, r[7:0]);
		hb = $urandom;
		tx_req++;
		for (int i = 0; i < 60; i++) begin
			apb(0, 12'h000, 0);
			if (rd[8] === 1'b1) break;
			repeat (100) @(posedge core_clk);
		end
		apb(0, 12'h014, 0);
		chk(rd, {24'h0, hb});
		apb(0, 12'h020, 0);
		chk(er, 1);
		chk(rd, 0);
		test_done;
	end
endmodule // config_switch_param_loader_bench
